// ==== logic/acq_sequencer.sv ====
// acquisition sequencer: modes, triggers, pacing, buffering, transfer
// Overview of operation
// - continuous mode streams every scan to the host, paced no faster than 30 kHz except in external-clock mode.
// - n-sample mode paces up to 200 kHz, stores to memory, sends only on transfer.
// - the sample memory addresses up to 30 million samples of buffered data.
// - parameters come by a config command and acquisition waits for start.
// - event-trigger mode waits for the external trigger, then takes n samples.
// - the event trigger is a falling edge and allows up to 200 kHz pacing.
// - external-clock mode starts one conversion per falling clock edge.
// - pre-trigger mode samples into a ring until the trigger, then holds n.
// - post-trigger mode idles until the trigger, then takes n samples.
// - several units start together from a shared trigger or shared clock.
// - eight 16-bit channels are converted together as one scan.
`timescale 1ns/1ps
`default_nettype none
`include "acq_cfg.svh"
module acq_sequencer (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire acq_pkg::cmd_e cmd_op,
  input wire acq_pkg::acq_cfg_s cmd_cfg,
  input wire logic trig_pin,
  input wire logic ext_clk_pin,
  output logic conv_start,
  input wire logic conv_done,
  input wire acq_pkg::scan_s conv_data,
  output logic mem_we,
  output logic mem_re,
  output logic [`ACQ_ADDR_BITS-1:0] mem_addr,
  output acq_pkg::scan_s mem_wdata,
  input wire acq_pkg::scan_s mem_rdata,
  output logic out_valid,
  input wire logic out_ready,
  output acq_pkg::scan_s out_data,
  output logic busy,
  output logic data_ready,
  output logic overrun
);
  typedef enum logic [2:0] {S_IDLE, S_ARMED, S_RUN, S_HOLD, S_XFER} state_e;
  localparam logic [`ACQ_DIV_BITS-1:0] CONT_MIN =
    `ACQ_DIV_BITS'(`ACQ_CONT_MIN_DIV);
  localparam logic [`ACQ_DIV_BITS-1:0] NSAMP_MIN =
    `ACQ_DIV_BITS'(`ACQ_NSAMP_MIN_DIV);
  localparam logic [`ACQ_ADDR_BITS-1:0] MEM_SCANS =
    `ACQ_ADDR_BITS'(`ACQ_MEM_SCANS);

  state_e state_r;
  acq_pkg::acq_cfg_s cfg_r;
  logic [`ACQ_SYNC_PINS-1:0] meta_r;
  logic [`ACQ_SYNC_PINS-1:0] sync_r;
  logic [`ACQ_SYNC_PINS-1:0] prev_r;
  logic [`ACQ_SYNC_PINS-1:0] fall;
  logic trig_fall;
  logic ext_fall;
  logic [`ACQ_DIV_BITS-1:0] eff_div;
  logic [`ACQ_DIV_BITS-1:0] div_cnt_r;
  logic tick;
  logic conv_start_r;
  logic conv_busy_r;
  logic [`ACQ_ADDR_BITS-1:0] wr_ptr_r;
  logic [`ACQ_ADDR_BITS-1:0] stored_r;
  logic ring_full_r;
  logic [`ACQ_ADDR_BITS-1:0] rd_ptr_r;
  logic [`ACQ_ADDR_BITS-1:0] rd_left_r;
  logic mem_re_r;
  logic rd_wait_r;
  logic mem_we_r;
  logic [`ACQ_ADDR_BITS-1:0] mem_addr_r;
  acq_pkg::scan_s mem_wdata_r;
  logic push_valid_r;
  acq_pkg::scan_s push_data_r;
  logic push_ready;
  logic overrun_r;
  logic is_cmd_start;
  logic is_cmd_stop;
  logic scan_in;
  logic n_done;
  logic [`ACQ_ADDR_BITS-1:0] last_idx;

  // shared pins, common start
  // two flops per pin, a third for the edge
  genvar gi;
  generate
    for (gi = 0; gi < `ACQ_SYNC_PINS; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          meta_r[gi] <= 1'b1;
          sync_r[gi] <= 1'b1;
          prev_r[gi] <= 1'b1;
        end else begin
          meta_r[gi] <= (gi == `ACQ_PIN_TRIG) ? trig_pin : ext_clk_pin;
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
      assign fall[gi] = prev_r[gi] && !sync_r[gi];
    end
  endgenerate
  assign trig_fall = fall[`ACQ_PIN_TRIG];
  assign ext_fall = fall[`ACQ_PIN_EXTCLK];

  assign is_cmd_start = cmd_valid && (cmd_op == acq_pkg::CMD_START);
  assign is_cmd_stop = cmd_valid && (cmd_op == acq_pkg::CMD_STOP);
  assign scan_in = conv_done && conv_busy_r && (state_r == S_RUN);
  assign last_idx = cfg_r.n_scans - 1'b1;
  assign n_done = scan_in && (cfg_r.mode == acq_pkg::XFER_NSAMP) &&
    (cfg_r.src != acq_pkg::SRC_PRE) && (stored_r == last_idx);

  always_comb begin
    eff_div = cfg_r.rate_div;
    if (cfg_r.mode == acq_pkg::XFER_CONT && eff_div < CONT_MIN) begin
      eff_div = CONT_MIN;
    end else if (eff_div < NSAMP_MIN) begin
      eff_div = NSAMP_MIN;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn || state_r != S_RUN || tick) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  always_comb begin
    if (cfg_r.src == acq_pkg::SRC_EXTCLK) begin
      tick = (state_r == S_RUN) && ext_fall;
    end else begin
      tick = (state_r == S_RUN) && (div_cnt_r == eff_div - 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      conv_start_r <= 1'b0;
      conv_busy_r <= 1'b0;
    end else begin
      conv_start_r <= tick && !conv_busy_r;
      if (conv_start_r) begin
        conv_busy_r <= 1'b1;
      end else if (conv_done) begin
        conv_busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cfg_r <= '{acq_pkg::XFER_CONT, acq_pkg::SRC_SOFT, '0, '0};
    end else if (cmd_valid && cmd_op == acq_pkg::CMD_CONFIG &&
                 state_r == S_IDLE) begin
      cfg_r <= cmd_cfg;
      if (cmd_cfg.n_scans > MEM_SCANS) begin
        cfg_r.n_scans <= MEM_SCANS;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= S_IDLE;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (is_cmd_start) begin
            if (cfg_r.src == acq_pkg::SRC_POST) begin
              state_r <= S_ARMED;
            end else begin
              state_r <= S_RUN;
            end
          end
        end
        S_ARMED: begin
          if (is_cmd_stop) begin
            state_r <= S_IDLE;
          end else if (trig_fall) begin
            state_r <= S_RUN;
          end
        end
        S_RUN: begin
          if (is_cmd_stop) begin
            state_r <= S_IDLE;
          end else if (cfg_r.src == acq_pkg::SRC_PRE && trig_fall) begin
            state_r <= S_HOLD;
          end else if (n_done) begin
            state_r <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (is_cmd_stop) begin
            state_r <= S_IDLE;
          end else if (cmd_valid && cmd_op == acq_pkg::CMD_XFER) begin
            state_r <= S_XFER;
          end
        end
        S_XFER: begin
          if (rd_left_r == '0 && !mem_re_r && !rd_wait_r &&
              !push_valid_r) begin
            state_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn || state_r == S_IDLE) begin
      wr_ptr_r <= '0;
      stored_r <= '0;
      ring_full_r <= 1'b0;
      mem_we_r <= 1'b0;
    end else begin
      mem_we_r <= scan_in && cfg_r.mode == acq_pkg::XFER_NSAMP;
      if (scan_in && cfg_r.mode == acq_pkg::XFER_NSAMP) begin
        mem_wdata_r <= conv_data;
        if (wr_ptr_r == last_idx) begin
          wr_ptr_r <= '0;
          ring_full_r <= 1'b1;
        end else begin
          wr_ptr_r <= wr_ptr_r + 1'b1;
        end
        if (!ring_full_r && stored_r != cfg_r.n_scans) begin
          stored_r <= stored_r + 1'b1;
        end
      end
    end
  end

  // reads one at a time; slow but the fifo never overflows
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_ptr_r <= '0;
      rd_left_r <= '0;
      mem_re_r <= 1'b0;
    end else if (state_r == S_HOLD) begin
      rd_ptr_r <= ring_full_r ? wr_ptr_r : '0;
      rd_left_r <= ring_full_r ? cfg_r.n_scans : stored_r;
      mem_re_r <= 1'b0;
    end else if (state_r == S_XFER) begin
      mem_re_r <= 1'b0;
      if (rd_left_r != '0 && !mem_re_r && !rd_wait_r && !push_valid_r &&
          push_ready) begin
        mem_re_r <= 1'b1;
        rd_left_r <= rd_left_r - 1'b1;
        rd_ptr_r <= (rd_ptr_r == last_idx) ? '0 : rd_ptr_r + 1'b1;
      end
    end else begin
      mem_re_r <= 1'b0;
    end
  end

  // memory answers one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= mem_re_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mem_addr_r <= '0;
    end else if (state_r == S_XFER) begin
      mem_addr_r <= rd_ptr_r;
    end else begin
      mem_addr_r <= wr_ptr_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      push_valid_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      push_valid_r <= 1'b0;
      if (scan_in && cfg_r.mode == acq_pkg::XFER_CONT) begin
        push_valid_r <= 1'b1;
        push_data_r <= conv_data;
      end else if (rd_wait_r) begin
        push_valid_r <= 1'b1;
        push_data_r <= mem_rdata;
      end
      // host too slow, or tick while a conversion is busy: scan lost, flagged until next start
      if ((push_valid_r && !push_ready) || (tick && conv_busy_r)) begin
        overrun_r <= 1'b1;
      end else if (is_cmd_start) begin
        overrun_r <= 1'b0;
      end
    end
  end

  scan_fifo #(
    .WIDTH(`ACQ_SCAN_BITS),
    .DEPTH(`ACQ_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(push_valid_r),
    .in_ready(push_ready),
    .in_data(push_data_r),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  assign conv_start = conv_start_r;
  assign mem_we = mem_we_r;
  assign mem_re = mem_re_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign busy = (state_r != S_IDLE);
  assign data_ready = (state_r == S_HOLD);
  assign overrun = overrun_r;

  // helper: cycles since last conversion start
  logic [`ACQ_DIV_BITS-1:0] since_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn || conv_start_r) begin
      since_r <= '0;
    end else if (since_r != '1) begin
      since_r <= since_r + 1'b1;
    end
  end
  logic started_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn || state_r == S_IDLE) begin
      started_r <= 1'b0;
    end else if (conv_start_r) begin
      started_r <= 1'b1;
    end
  end

  sequence s_armed_hit;
    state_r == S_ARMED && trig_fall && !is_cmd_stop;
  endsequence
  sequence s_run_next;
    ##1 state_r == S_RUN;
  endsequence

  property p_cont_rate;
    @(posedge sys_clk) disable iff (!rstn)
    conv_start_r && started_r && cfg_r.mode == acq_pkg::XFER_CONT &&
      cfg_r.src != acq_pkg::SRC_EXTCLK |-> since_r >= CONT_MIN - 1'b1;
  endproperty
  a_cont_rate: assert property (p_cont_rate)
    else $error("continuous pacing too fast");

  property p_nsamp_silent;
    @(posedge sys_clk) disable iff (!rstn)
    cfg_r.mode == acq_pkg::XFER_NSAMP && state_r == S_RUN |=> !push_valid_r;
  endproperty
  a_nsamp_silent: assert property (p_nsamp_silent)
    else $error("buffered scan sent before transfer");

  property p_cap;
    @(posedge sys_clk) disable iff (!rstn)
    state_r != S_IDLE |-> cfg_r.n_scans <= MEM_SCANS;
  endproperty
  a_cap: assert property (p_cap)
    else $error("scan count beyond memory");

  property p_wait_start;
    @(posedge sys_clk) disable iff (!rstn)
    state_r == S_IDLE && !is_cmd_start |=> state_r == S_IDLE;
  endproperty
  a_wait_start: assert property (p_wait_start)
    else $error("left idle without start");

  property p_trig_run;
    @(posedge sys_clk) disable iff (!rstn)
    s_armed_hit |-> s_run_next;
  endproperty
  a_trig_run: assert property (p_trig_run)
    else $error("trigger did not start acquisition");

  property p_armed_hold;
    @(posedge sys_clk) disable iff (!rstn)
    state_r == S_ARMED && !trig_fall && !is_cmd_stop |=> state_r == S_ARMED;
  endproperty
  a_armed_hold: assert property (p_armed_hold)
    else $error("armed state left without trigger");

  property p_one_edge;
    @(posedge sys_clk) disable iff (!rstn)
    trig_fall |=> !trig_fall ##1 !trig_fall;
  endproperty
  a_one_edge: assert property (p_one_edge)
    else $error("trigger edge seen twice");

  property p_ext_conv;
    @(posedge sys_clk) disable iff (!rstn)
    state_r == S_RUN && cfg_r.src == acq_pkg::SRC_EXTCLK && ext_fall &&
      !conv_busy_r |=> conv_start_r ##1 !conv_start_r;
  endproperty
  a_ext_conv: assert property (p_ext_conv)
    else $error("ext edge gave no single conversion");

  property p_pre_stop;
    @(posedge sys_clk) disable iff (!rstn)
    state_r == S_RUN && cfg_r.src == acq_pkg::SRC_PRE && trig_fall &&
      !is_cmd_stop |=> state_r == S_HOLD && data_ready;
  endproperty
  a_pre_stop: assert property (p_pre_stop)
    else $error("pre-trigger did not hold data");

  property p_scan_push;
    @(posedge sys_clk) disable iff (!rstn)
    scan_in && cfg_r.mode == acq_pkg::XFER_CONT |=>
      push_valid_r && push_data_r == $past(conv_data);
  endproperty
  a_scan_push: assert property (p_scan_push)
    else $error("scan not forwarded whole");
endmodule
`default_nettype wire

// ==== logic/scan_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module scan_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== pkg/acq_cfg.svh ====
// timing, size and layout constants of the acquisition sequencer
`ifndef ACQ_CFG_SVH
`define ACQ_CFG_SVH
`define ACQ_CLK_HZ 100000000
`define ACQ_CONT_MAX_HZ 30000
`define ACQ_NSAMP_MAX_HZ 200000
`define ACQ_CONT_MIN_DIV ((`ACQ_CLK_HZ + `ACQ_CONT_MAX_HZ - 1) / `ACQ_CONT_MAX_HZ)
`define ACQ_NSAMP_MIN_DIV ((`ACQ_CLK_HZ + `ACQ_NSAMP_MAX_HZ - 1) / `ACQ_NSAMP_MAX_HZ)
`define ACQ_CHANNELS 8
`define ACQ_SAMPLE_BITS 16
`define ACQ_SCAN_BITS (`ACQ_CHANNELS * `ACQ_SAMPLE_BITS)
`define ACQ_MEM_SAMPLES 30000000
`define ACQ_MEM_SCANS (`ACQ_MEM_SAMPLES / `ACQ_CHANNELS)
`define ACQ_ADDR_BITS 22
`define ACQ_DIV_BITS 16
`define ACQ_FIFO_DEPTH 8
`define ACQ_SYNC_PINS 2
`define ACQ_PIN_TRIG 0
`define ACQ_PIN_EXTCLK 1
`endif

// ==== pkg/acq_pkg.sv ====
// types shared by the acquisition sequencer and its callers
`include "acq_cfg.svh"
package acq_pkg;
  typedef enum logic [0:0] {XFER_CONT, XFER_NSAMP} xfer_mode_e;
  typedef enum logic [1:0] {SRC_SOFT, SRC_EXTCLK, SRC_PRE, SRC_POST}
    start_src_e;
  typedef enum logic [1:0] {CMD_CONFIG, CMD_START, CMD_STOP, CMD_XFER} cmd_e;
  typedef struct packed {
    xfer_mode_e mode;
    start_src_e src;
    logic [`ACQ_ADDR_BITS-1:0] n_scans;
    logic [`ACQ_DIV_BITS-1:0] rate_div;
  } acq_cfg_s;
  typedef struct packed {
    logic [`ACQ_CHANNELS-1:0][`ACQ_SAMPLE_BITS-1:0] ch;
  } scan_s;
endpackage

// ==== testbench/acq_far_model.sv ====
// converter, scan memory and pin source facing the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acq_cfg.svh"
module acq_far_model #(
  parameter int LAT = 4,
  parameter int PULSE = 150
) (
  input wire logic sys_clk,
  input wire logic conv_start,
  output logic conv_done,
  output acq_pkg::scan_s conv_data,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [`ACQ_ADDR_BITS-1:0] mem_addr,
  input wire acq_pkg::scan_s mem_wdata,
  output acq_pkg::scan_s mem_rdata,
  output logic trig_pin,
  output logic ext_clk_pin,
  output int n_conv
);
  // only 64 scans kept, enough for short runs
  acq_pkg::scan_s mem [64];
  int left;
  initial begin
    conv_done = 1'b0;
    conv_data = '0;
    mem_rdata = '0;
    trig_pin = 1'b1;
    ext_clk_pin = 1'b1;
    n_conv = 0;
    left = 0;
  end
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (conv_start) left <= LAT;
    else if (left > 0) left <= left - 1;
    if (left == 1 && !conv_start) begin
      conv_done <= 1'b1;
      for (int i = 0; i < 8; i++) conv_data.ch[i] <= {n_conv[11:0], i[3:0]};
      n_conv <= n_conv + 1;
    end
  end
  // scan store, read valid next cycle
  always @(posedge sys_clk) begin
    if (mem_we) mem[mem_addr[5:0]] <= mem_wdata;
    mem_rdata <= mem_re ? mem[mem_addr[5:0]] : ~mem_rdata;
  end
  task automatic pin_set(input logic clk_pin, input logic lvl);
    @(posedge sys_clk);
    if (clk_pin) ext_clk_pin <= lvl;
    else trig_pin <= lvl;
  endtask
  // low for the 1.5 us minimum width
  task automatic pin_pulse(input logic clk_pin);
    pin_set(clk_pin, 1'b0);
    repeat (PULSE) @(posedge sys_clk);
    pin_set(clk_pin, 1'b1);
    repeat (PULSE) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ==== testbench/acquisition_trigger_sequencer_bench.sv ====
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acq_cfg.svh"
`define CHK(a, e) chk(128'(a), 128'(e))
`define WAITV(c, lim) for (int w = 0; w < (lim) && !(c); w++) @(negedge sys_clk)
module acquisition_trigger_sequencer_bench;
  typedef struct {
    acq_pkg::start_src_e src;
    int n;
    int gap;
  } row_s;
  row_s rows [4] = '{
    '{acq_pkg::SRC_SOFT, 3, `ACQ_NSAMP_MIN_DIV},
    '{acq_pkg::SRC_SOFT, 1, 0},
    '{acq_pkg::SRC_POST, 2, `ACQ_NSAMP_MIN_DIV},
    '{acq_pkg::SRC_EXTCLK, 3, 0}
  };
  logic sys_clk, rstn, cmd_valid, out_ready, conv_start, conv_done;
  logic mem_we, mem_re, trig_pin, ext_clk_pin, out_valid, busy;
  logic data_ready, overrun;
  logic [`ACQ_ADDR_BITS-1:0] mem_addr;
  acq_pkg::cmd_e cmd_op;
  acq_pkg::acq_cfg_s cmd_cfg;
  acq_pkg::scan_s conv_data, mem_wdata, mem_rdata, out_data;
  acq_pkg::scan_s got [$];
  int n_conv, k0, n_mismatch, check_count, gap_cnt, min_gap;

  acq_sequencer i_dut (.sys_clk, .rstn, .cmd_valid, .cmd_op, .cmd_cfg,
    .trig_pin, .ext_clk_pin, .conv_start, .conv_done, .conv_data, .mem_we,
    .mem_re, .mem_addr, .mem_wdata, .mem_rdata, .out_valid, .out_ready,
    .out_data, .busy, .data_ready, .overrun);
  acq_far_model i_far (.sys_clk, .conv_start, .conv_done, .conv_data,
    .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata, .trig_pin,
    .ext_clk_pin, .n_conv);

  // collect stream words, track spacing of conversions
  always @(posedge sys_clk) begin
    if (out_valid && out_ready) got.push_back(out_data);
    gap_cnt <= conv_start ? 0 : gap_cnt + 1;
    if (conv_start && gap_cnt + 1 < min_gap) min_gap <= gap_cnt + 1;
  end

  task automatic chk(input logic [127:0] a, input logic [127:0] e);
    check_count++;
    if (a !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic acq_pkg::scan_s pat(input int k);
    acq_pkg::scan_s s;
    for (int i = 0; i < `ACQ_CHANNELS; i++) s.ch[i] = {k[11:0], i[3:0]};
    return s;
  endfunction
  task automatic cmd(input acq_pkg::cmd_e op, input acq_pkg::acq_cfg_s c);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_cfg <= c;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
  endtask
  // rate_div of 1 must be raised to the mode minimum
  task automatic run(input acq_pkg::start_src_e s,
    input acq_pkg::xfer_mode_e m, input int n);
    got.delete();
    k0 = n_conv;
    cmd(acq_pkg::CMD_CONFIG, '{m, s, 22'(n), 16'h0001});
    @(negedge sys_clk);
    `CHK(busy, 0);
    min_gap = 32'h7fff_ffff;
    cmd(acq_pkg::CMD_START, cmd_cfg);
    @(negedge sys_clk);
    `CHK({busy, overrun}, 2'h2);
  endtask
  task automatic drain(input int n, input int base, input int lim);
    `WAITV(got.size() >= n, lim);
    for (int j = 0; j < n; j++) `CHK(got[j], pat(base + j));
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #900000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = acq_pkg::CMD_CONFIG;
    cmd_cfg = '0;
    out_ready = 1'b1;
    n_mismatch = 0;
    check_count = 0;
    gap_cnt = 0;
    min_gap = 0;
    // pins idle high, so two edges of reset suffice
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    `CHK({busy, data_ready, overrun, out_valid, conv_start, mem_we}, 0);
    k0 = n_conv;
    cmd(acq_pkg::CMD_XFER, cmd_cfg);
    repeat (100) @(negedge sys_clk);
    `CHK({busy, mem_re, out_valid, 8'(n_conv - k0)}, 0);
    foreach (rows[r]) begin
      run(rows[r].src, acq_pkg::XFER_NSAMP, rows[r].n);
      if (rows[r].src == acq_pkg::SRC_POST) begin
        repeat (800) @(negedge sys_clk);
        `CHK(n_conv - k0, 0);
        i_far.pin_pulse(1'b0);
      end
      if (rows[r].src == acq_pkg::SRC_EXTCLK) begin
        for (int e = 1; e <= rows[r].n + 1; e++) begin
          i_far.pin_pulse(1'b1);
          `CHK(n_conv - k0, (e > rows[r].n) ? rows[r].n : e);
        end
      end
      `WAITV(data_ready === 1'b1, 5000);
      `CHK({data_ready, 8'(got.size())}, 9'h100);
      `CHK(n_conv - k0, rows[r].n);
      `CHK(min_gap >= rows[r].gap, 1);
      cmd(acq_pkg::CMD_XFER, cmd_cfg);
      drain(rows[r].n, k0, 2000);
      `WAITV(busy === 1'b0, 200);
      `CHK({busy, data_ready, 8'(got.size())}, rows[r].n);
    end
    run(acq_pkg::SRC_SOFT, acq_pkg::XFER_CONT, 0);
    drain(3, k0, 12000);
    `CHK({min_gap >= `ACQ_CONT_MIN_DIV, data_ready}, 2'h2);
    cmd(acq_pkg::CMD_STOP, cmd_cfg);
    `WAITV(busy === 1'b0, 100);
    `CHK(busy, 0);
    // stall the host until the fifo overflows
    @(posedge sys_clk);
    out_ready <= 1'b0;
    run(acq_pkg::SRC_SOFT, acq_pkg::XFER_CONT, 0);
    `WAITV(n_conv - k0 >= 10, 40000);
    `CHK({overrun, out_valid, 8'(got.size())}, 10'h300);
    @(posedge sys_clk);
    out_ready <= 1'b1;
    drain(`ACQ_FIFO_DEPTH, k0, 100);
    cmd(acq_pkg::CMD_STOP, cmd_cfg);
    repeat (20) @(negedge sys_clk);
    `CHK({busy, out_valid}, 0);
    run(acq_pkg::SRC_PRE, acq_pkg::XFER_NSAMP, 4);
    `WAITV(n_conv - k0 >= 6, 5000);
    // trigger just after a scan lands, away from a conversion
    `WAITV(conv_done === 1'b1, 1000);
    i_far.pin_set(1'b0, 1'b0);
    `WAITV(data_ready === 1'b1, 20);
    k0 = n_conv;
    `CHK({data_ready, trig_pin}, 2'h2);
    repeat (150) @(posedge sys_clk);
    i_far.pin_set(1'b0, 1'b1);
    cmd(acq_pkg::CMD_XFER, cmd_cfg);
    drain(4, k0 - 4, 500);
    `WAITV(busy === 1'b0, 200);
    `CHK({busy, 8'(got.size())}, 4);
    tally_and_finish();
  end
endmodule
`default_nettype wire
